// [verilog/pss_core.sv]
// Program sequencer: program counter, stack, table read and register slave.
// Assumes the decoder issues one command per instruction cycle and the
// program memory returns data the clock after the address.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Contract
// RULE1: PC steps by one per executed instruction unless branching.
// RULE2: Only PC low byte is a software read/write register.
// RULE3: PC is three high bits above an eight-bit low byte.
// RULE4: Jump, call, interrupt and reset load the target directly.
// RULE5: A taken skip discards the prefetched word as a dummy cycle.
// RULE6: Writing PC low byte jumps within the current 256-word page.
// RULE7: Each PC low byte write jump inserts one dummy cycle.
// RULE8: Stack has six PC-only levels, hidden from software.
// RULE9: Call or interrupt acknowledge pushes the PC.
// RULE10: Return instructions reload PC from the newest entry.
// RULE11: Reset leaves the stack empty.
// RULE12: Full stack holds back interrupt acknowledge, request stays flagged.
// RULE13: Held interrupt is acknowledged once a return frees a level.
// RULE14: A call still runs on a full stack.
// RULE15: Overflow loses the oldest saved PC.
// RULE16: ALU updates status flags; handled outside this block.
// RULE17: Program memory is 2K words of 16 bits.
// RULE18: Reset starts execution at address zero.
// RULE19: Both table pointers together form the table address.
// RULE20: Table read low byte to destination, high byte to table high.
// RULE21: Paged table read offsets low pointer in the high-pointer page.
// RULE22: Table high byte is read-only, changed only by table reads.
// RULE23: Every table read takes two instruction cycles.
// RULE24: Software masks interrupts around main-routine table reads.
// RULE25: Four phases per instruction cycle, PC steps at the first.
// RULE26: Jumps and calls take two instruction cycles.
// RULE27: Last-page table read uses final page with low pointer offset.
// RULE28: Popping an empty stack keeps the level at empty.
module pss_core #(
    parameter int PC_WIDTH = pss_pkg::PC_W,
    parameter int WORD_WIDTH = pss_pkg::WORD_W
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire pss_pkg::pss_cmd_type i_cmd,
    input wire logic i_irq_pending,
    input wire logic [pss_pkg::PC_W-1:0] i_irq_vector,
    output logic o_irq_ack,
    output logic [pss_pkg::PC_W-1:0] o_pmem_addr,
    input wire logic [pss_pkg::WORD_W-1:0] i_pmem_data,
    output logic [pss_pkg::WORD_W-1:0] o_instr,
    output logic o_instr_valid,
    output logic [1:0] o_phase,
    output pss_pkg::pss_wr_type o_dwr,
    output logic [pss_pkg::PC_W-1:0] o_pc,
    output logic o_stack_full,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);
    import pss_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Phase generator and stack.

    logic cyc_start;
    logic push;
    logic pop;
    logic [PC_W-1:0] stk_top;
    logic stk_full;
    logic [PC_W-1:0] push_val;

    pss_phase u_phase (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .o_phase(o_phase),
        .o_cycle_start(cyc_start)
    );

    pss_stack #(.DEPTH(STACK_DEPTH)) u_stack (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n), // RULE11
        .i_ce(i_ce),
        .i_push(push),
        .i_pop(pop),
        .i_data(push_val),
        .o_top(stk_top),
        .o_full(stk_full) // RULE8
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state.

    typedef enum logic [3:0] {
        PSS_RUN = 4'b0001,
        PSS_DUMMY = 4'b0010,
        PSS_TAB = 4'b0100,
        PSS_HALT = 4'b1000
    } pss_state_type;

    pss_state_type st_r;
    pss_state_type st_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic [7:0] tblp_r;
    logic [7:0] tblp_nxt;
    logic [PCH_W-1:0] tbhp_r;
    logic [PCH_W-1:0] tbhp_nxt;
    logic [7:0] tbh_r;
    logic [7:0] tbh_nxt;
    logic [PC_W-1:0] tab_addr_r;
    logic [PC_W-1:0] tab_addr_nxt;
    logic [7:0] tab_dest_r;
    logic [7:0] tab_dest_nxt;
    pss_wr_type dwr_r;
    pss_wr_type dwr_nxt;
    logic [WORD_W-1:0] instr_r;
    logic [WORD_W-1:0] instr_nxt;
    logic ivalid_r;
    logic ivalid_nxt;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] rdat_r;
    logic [31:0] rdat_nxt;
    logic irq_ack;
    logic pc_low_wr;

    function automatic logic [PC_W-1:0] page_addr(input logic [PCH_W-1:0] page, input logic [7:0] off);
        page_addr = {page, off};
    endfunction

    // Bus write to PC low byte, taken once per request.
    assign pc_low_wr = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r && i_wb_sel[0] && (i_wb_adr == REG_PC_LOW);

    // Interrupt acknowledged only at a cycle boundary with a free stack level.
    assign irq_ack = cyc_start && (st_r == PSS_RUN) && i_irq_pending && !stk_full; // RULE12 RULE13
    assign push = cyc_start && (st_r == PSS_RUN) && (irq_ack || (i_cmd.valid && i_cmd.op == PSS_OP_CALL)); // RULE9 RULE14
    // An interrupt taken at the same boundary drops the command, so no pop then.
    assign pop = cyc_start && (st_r == PSS_RUN) && !irq_ack && i_cmd.valid && i_cmd.op == PSS_OP_RETURN; // RULE10 RULE28
    assign push_val = pc_r;

    always_comb begin
        st_nxt = st_r;
        pc_nxt = pc_r;
        tblp_nxt = tblp_r;
        tbhp_nxt = tbhp_r;
        tbh_nxt = tbh_r;
        tab_addr_nxt = tab_addr_r;
        tab_dest_nxt = tab_dest_r;
        dwr_nxt = '0;
        instr_nxt = instr_r;
        ivalid_nxt = 1'b0;
        if (cyc_start) begin
            case (st_r)
                PSS_RUN: begin
                    instr_nxt = i_pmem_data;
                    ivalid_nxt = 1'b1;
                    pc_nxt = pc_r + 11'd1; // RULE1 RULE25
                    if (irq_ack) begin
                        pc_nxt = i_irq_vector; // RULE4
                        st_nxt = PSS_DUMMY;
                    end else if (i_cmd.valid) begin
                        case (i_cmd.op)
                            PSS_OP_JUMP, PSS_OP_CALL: begin
                                pc_nxt = i_cmd.target; // RULE4 RULE26
                                st_nxt = PSS_DUMMY;
                            end
                            PSS_OP_RETURN: begin
                                pc_nxt = stk_top; // RULE10
                                st_nxt = PSS_DUMMY;
                            end
                            PSS_OP_SKIP: begin
                                st_nxt = PSS_DUMMY; // RULE5
                            end
                            PSS_OP_TABRD: begin
                                tab_addr_nxt = page_addr(tbhp_r, tblp_r); // RULE19 RULE21
                                tab_dest_nxt = i_cmd.dest;
                                pc_nxt = pc_r;
                                st_nxt = PSS_TAB; // RULE23
                            end
                            PSS_OP_TAB_LAST: begin
                                tab_addr_nxt = page_addr(LAST_PAGE, tblp_r); // RULE27
                                tab_dest_nxt = i_cmd.dest;
                                pc_nxt = pc_r;
                                st_nxt = PSS_TAB; // RULE23
                            end
                            default: begin
                                st_nxt = PSS_RUN;
                            end
                        endcase
                    end
                end
                PSS_DUMMY: begin
                    // Prefetched word is dropped; the fetch of the new target fills the pipe.
                    pc_nxt = pc_r + 11'd1; // RULE5 RULE7
                    instr_nxt = i_pmem_data;
                    st_nxt = PSS_RUN;
                end
                PSS_TAB: begin
                    dwr_nxt.we = 1'b1; // RULE20
                    dwr_nxt.dest = tab_dest_r;
                    dwr_nxt.data = i_pmem_data[7:0];
                    tbh_nxt = i_pmem_data[15:8]; // RULE20 RULE22
                    st_nxt = PSS_RUN;
                end
                default: begin
                    st_nxt = PSS_RUN;
                end
            endcase
        end
        // The bus write comes last so that it wins over the sequencer update.
        if (pc_low_wr) begin
            pc_nxt = {pc_r[PC_W-1:8], i_wb_dat[7:0]}; // RULE6 RULE2
            st_nxt = PSS_DUMMY; // RULE7
        end
        if (i_wb_cyc && i_wb_stb && i_wb_we && !ack_r && i_wb_sel[0]) begin
            if (i_wb_adr == REG_TBLP) begin
                tblp_nxt = i_wb_dat[7:0];
            end else if (i_wb_adr == REG_TBHP) begin
                tbhp_nxt = i_wb_dat[PCH_W-1:0];
            end
        end
    end

    // Wishbone slave: one registered ack a clock after the strobe, unmapped reads return zero.
    always_comb begin
        ack_nxt = i_wb_cyc && i_wb_stb && !ack_r;
        rdat_nxt = 32'h0000_0000;
        if (i_wb_adr == REG_PC_LOW) begin
            rdat_nxt = {24'h00_0000, pc_r[7:0]}; // RULE2 RULE3
        end else if (i_wb_adr == REG_TBLP) begin
            rdat_nxt = {24'h00_0000, tblp_r};
        end else if (i_wb_adr == REG_TBHP) begin
            rdat_nxt = {29'h0000_0000, tbhp_r};
        end else if (i_wb_adr == REG_TABLE_HIGH) begin
            rdat_nxt = {24'h00_0000, tbh_r};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r <= PSS_RUN;
            pc_r <= RESET_VECTOR; // RULE18 RULE4
            tblp_r <= TBL_PTR_RESET;
            tbhp_r <= '0;
            tbh_r <= TBH_RESET;
            tab_addr_r <= '0;
            tab_dest_r <= '0;
            dwr_r <= '0;
            instr_r <= '0;
            ivalid_r <= 1'b0;
            ack_r <= 1'b0;
            rdat_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            tblp_r <= tblp_nxt;
            tbhp_r <= tbhp_nxt;
            tbh_r <= tbh_nxt;
            tab_addr_r <= tab_addr_nxt;
            tab_dest_r <= tab_dest_nxt;
            dwr_r <= dwr_nxt;
            instr_r <= instr_nxt;
            ivalid_r <= ivalid_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // Program memory address: table address during table cycle, PC otherwise.
    assign o_pmem_addr = (st_r == PSS_TAB) ? tab_addr_r : pc_r; // RULE17
    assign o_instr = instr_r;
    assign o_instr_valid = ivalid_r;
    assign o_dwr = dwr_r;
    assign o_pc = pc_r;
    assign o_stack_full = stk_full;
    assign o_irq_ack = irq_ack;
    assign o_wb_ack = ack_r;
    assign o_wb_dat = rdat_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    AST_RESET_PC: assert property (@(posedge i_clk) $rose(i_rst_n) |-> pc_r == RESET_VECTOR) // RULE18
        else $error("PC not at reset vector after reset");
    AST_NO_ACK_FULL: assert property (@(posedge i_clk) disable iff (!i_rst_n) stk_full |-> !o_irq_ack) // RULE12
        else $error("Interrupt acknowledged with full stack");
    // An idle command slot, flagged valid or not, must still advance the PC by one.
    AST_STEP: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
        (cyc_start && st_r == PSS_RUN && !irq_ack && (!i_cmd.valid || i_cmd.op == PSS_OP_NONE) && !pc_low_wr)
        |=> pc_r == $past(pc_r) + 11'd1)
        else $error("PC did not step by one");
    AST_JUMP: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE4
        (i_ce && cyc_start && st_r == PSS_RUN && !irq_ack && i_cmd.valid && i_cmd.op == PSS_OP_JUMP && !pc_low_wr)
        |=> pc_r == $past(i_cmd.target) && st_r == PSS_DUMMY)
        else $error("Jump target not loaded");
    AST_PC_LOW_PAGE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE6
        (i_ce && pc_low_wr) |=> pc_r[10:8] == $past(pc_r[10:8]) && pc_r[7:0] == $past(i_wb_dat[7:0]))
        else $error("PC low byte write left the page");
    AST_PC_LOW_DUMMY: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
        (i_ce && pc_low_wr) |=> st_r == PSS_DUMMY)
        else $error("No dummy cycle after PC low byte write");
    AST_RETURN: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE10
        (i_ce && pop && !pc_low_wr) |=> pc_r == $past(stk_top))
        else $error("Return did not restore PC");
    AST_TAB_WRITE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE20
        (i_ce && cyc_start && st_r == PSS_TAB && !pc_low_wr) |=> dwr_r.we && tbh_r == $past(i_pmem_data[15:8]))
        else $error("Table read result not written");
    AST_TBH_STABLE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE22
        !(st_r == PSS_TAB && cyc_start) |=> $stable(tbh_r))
        else $error("Table high byte changed outside table read");
    AST_TABL_ADDR: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE27
        (i_ce && cyc_start && st_r == PSS_RUN && !irq_ack && i_cmd.valid && i_cmd.op == PSS_OP_TAB_LAST)
        |=> tab_addr_r == {LAST_PAGE, $past(tblp_r)})
        else $error("Last-page table address wrong");
    // A discarded slot issues nothing and hands back to normal fetch after one cycle.
    AST_DUMMY_ONE: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
        (cyc_start && st_r == PSS_DUMMY && !pc_low_wr) |=> st_r == PSS_RUN && !o_instr_valid)
        else $error("Dummy cycle not single or issued an instruction");
    AST_TAB_END: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE23
        (cyc_start && st_r == PSS_TAB && !pc_low_wr) |=> st_r == PSS_RUN && !o_instr_valid)
        else $error("Table read did not end after its second cycle");
    // A call on a full stack still branches, stays full and keeps its return address.
    AST_CALL_FULL: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE14
        (cyc_start && st_r == PSS_RUN && !irq_ack && i_cmd.valid && i_cmd.op == PSS_OP_CALL
        && stk_full && !pc_low_wr)
        |=> pc_r == $past(i_cmd.target) && stk_full && stk_top == $past(pc_r))
        else $error("Call on full stack mishandled");
    COV_CALL: cover property (@(posedge i_clk) disable iff (!i_rst_n) push && !irq_ack);
    COV_IRQ_HELD: cover property (@(posedge i_clk) disable iff (!i_rst_n) i_irq_pending && stk_full && cyc_start);
    COV_TAB: cover property (@(posedge i_clk) disable iff (!i_rst_n) dwr_r.we);
    COV_PC_LOW: cover property (@(posedge i_clk) disable iff (!i_rst_n) pc_low_wr);
    COV_IRQ_LATE: cover property (@(posedge i_clk) disable iff (!i_rst_n) pop ##[4:8] o_irq_ack);
endmodule

// [verilog/pss_pkg.sv]
// Shared constants and carrier types for the program sequencer.
// Assumes a single 40 MHz clock and synchronous active-low reset.
package pss_pkg;
    localparam int PC_W = 11;
    localparam int PCH_W = 3;
    localparam int WORD_W = 16;
    localparam int STACK_DEPTH = 6;
    localparam int PHASES = 4;
    localparam logic [10:0] RESET_VECTOR = 11'h000;
    localparam logic [2:0] LAST_PAGE = 3'h7;
    localparam logic [1:0] PHASE_FETCH = 2'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [7:0] TBL_PTR_RESET = 8'h00;
    localparam logic [7:0] TBH_RESET = 8'h00;
    // Wishbone register map, byte addresses.
    localparam logic [3:0] REG_PC_LOW = 4'h0;
    localparam logic [3:0] REG_TBLP = 4'h4;
    localparam logic [3:0] REG_TBHP = 4'h8;
    localparam logic [3:0] REG_TABLE_HIGH = 4'hc;

    typedef enum logic [5:0] {
        PSS_OP_NONE = 6'h00,
        PSS_OP_JUMP = 6'h01,
        PSS_OP_CALL = 6'h02,
        PSS_OP_RETURN = 6'h03,
        PSS_OP_SKIP = 6'h04,
        PSS_OP_TABRD = 6'h05,
        PSS_OP_TAB_LAST = 6'h06
    } pss_op_type;

    typedef struct packed {
        logic valid;
        pss_op_type op;
        logic [10:0] target;
        logic [7:0] dest;
    } pss_cmd_type;

    typedef struct packed {
        logic we;
        logic [7:0] dest;
        logic [7:0] data;
    } pss_wr_type;
endpackage

// [verilog/pss_phase.sv]
// Four-phase instruction cycle generator.
// Assumes the core clock enable freezes it.
`timescale 1ns/1ps
module pss_phase (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    output logic [1:0] o_phase,
    output logic o_cycle_start
);
    import pss_pkg::*;
    logic [1:0] phase_r;
    logic [1:0] phase_nxt;
    always_comb begin
        phase_nxt = phase_r + 2'd1;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            phase_r <= PHASE_FETCH;
        end else if (i_ce) begin
            phase_r <= phase_nxt;
        end
    end
    assign o_phase = phase_r;
    assign o_cycle_start = (phase_r == PHASE_LAST) && i_ce;
endmodule

// [verilog/pss_stack.sv]
// Six-level return-address stack, shifting, oldest entry lost on overflow.
// Assumes push and pop are exclusive one-cycle pulses.
`timescale 1ns/1ps
module pss_stack #(
    parameter int DEPTH = pss_pkg::STACK_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic [pss_pkg::PC_W-1:0] i_data,
    output logic [pss_pkg::PC_W-1:0] o_top,
    output logic o_full
);
    import pss_pkg::*;
    logic [PC_W-1:0] mem_r [DEPTH];
    logic [PC_W-1:0] mem_nxt [DEPTH];
    logic [3:0] lvl_r;
    logic [3:0] lvl_nxt;
    always_comb begin
        lvl_nxt = lvl_r;
        for (int i = 0; i < DEPTH; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (i_push) begin
            // Entry 0 is newest; shifting drops the oldest.
            for (int i = DEPTH - 1; i > 0; i--) begin
                mem_nxt[i] = mem_r[i-1]; // RULE15
            end
            mem_nxt[0] = i_data;
            if (lvl_r != 4'(DEPTH)) begin
                lvl_nxt = lvl_r + 4'd1;
            end
        end else if (i_pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                mem_nxt[i] = mem_r[i+1];
            end
            if (lvl_r != 4'd0) begin
                lvl_nxt = lvl_r - 4'd1;
            end
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lvl_r <= 4'd0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= '0;
            end
        end else if (i_ce) begin
            lvl_r <= lvl_nxt;
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    end
    assign o_top = mem_r[0];
    assign o_full = (lvl_r == 4'(DEPTH)); // RULE8
endmodule

// [tb/pss_pmem_model.sv]
// Program memory model for the sequencer bench.
// Assumes the sequencer samples the read word at its next cycle boundary, at least one clock after it presents the address.
`timescale 1ns/1ps
module pss_pmem_model (
    input wire logic i_clk,
    input wire logic [10:0] i_addr,
    output logic [15:0] o_data
);
    // Each word carries its own page and offset, so a wrong address shows in the data.
    always_ff @(posedge i_clk) begin
        o_data <= {i_addr[10:8], 5'h15, i_addr[7:0]};
    end
endmodule

// [tb/tb.sv]
// Self-checking bench for the program sequencer: commands, stack, table reads and register bus.
// Assumes the program memory model and a single 40 MHz clock.
`timescale 1ns/1ps
module tb;
    import pss_pkg::*;
    logic clk, rst_n, ce, irq, ack, full, iv, wcyc, wstb, wwe, wack;
    logic [1:0] ph;
    logic [3:0] wadr, wsel;
    logic [10:0] vec, pc, paddr, lastpc, t, q;
    logic [15:0] pdat, instr, w;
    logic [31:0] wdat, rdat;
    logic [7:0] b, lp;
    logic [2:0] hp;
    pss_cmd_type cmd;
    pss_wr_type dwr;
    int err_count, checks_done, n;
    logic [31:0] q_rd[$];
    logic [15:0] q_dwr[$];
    logic [10:0] stk[$];

    pss_core u_dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cmd(cmd), .i_irq_pending(irq),
        .i_irq_vector(vec), .o_irq_ack(ack), .o_pmem_addr(paddr), .i_pmem_data(pdat), .o_instr(instr),
        .o_instr_valid(iv), .o_phase(ph), .o_dwr(dwr), .o_pc(pc), .o_stack_full(full), .i_wb_cyc(wcyc),
        .i_wb_stb(wstb), .i_wb_we(wwe), .i_wb_adr(wadr), .i_wb_sel(wsel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(wack));
    pss_pmem_model u_mem (.i_clk(clk), .i_addr(paddr), .o_data(pdat));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] word(input logic [10:0] a);
        return {a[10:8], 5'h15, a[7:0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        chk("bus ack drop", wack, 0);
        wcyc <= 1'b1;
        wstb <= 1'b1;
        wwe <= we;
        wadr <= a;
        wdat <= d;
        do @(posedge clk); while (wack !== 1'b1);
        wcyc <= 1'b0;
        wstb <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        q_rd.push_back(exp);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    // Sends one command at a boundary, always leaving a free boundary before it.
    task automatic issue(input pss_op_type op, input logic [10:0] tg, input logic [7:0] d);
        repeat (2) begin
            @(posedge clk);
            while (ph !== 2'h2) @(posedge clk);
        end
        cmd <= '{1'b1, op, tg, d};
        @(posedge clk);
        lastpc = pc;
        cmd <= '{1'b1, PSS_OP_NONE, 11'h000, 8'h00};
        #1;
    endtask

    task automatic count_iv(input int exp);
        n = 0;
        repeat (4) begin
            @(posedge clk);
            #1;
            n += int'(iv);
        end
        chk("issued count", n, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (wack === 1'b1 && wwe === 1'b0) chk("bus read", rdat, q_rd.size() > 0 ? q_rd.pop_front() : 'x);
        if (dwr.we === 1'b1) chk("table write", {dwr.dest, dwr.data}, q_dwr.size() > 0 ? q_dwr.pop_front() : 'x);
    end

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #500000;
        chk("watchdog", 0, 1);
        final_report();
    end

    initial begin
        void'($urandom(32'hd42c));
        rst_n = 1'b0;
        ce = 1'b1;
        irq = 1'b0;
        vec = 11'h3c0;
        cmd = '{1'b1, PSS_OP_NONE, 11'h000, 8'h00};
        wcyc = 1'b0;
        wstb = 1'b0;
        wwe = 1'b0;
        wadr = 4'h0;
        wsel = 4'hf;
        wdat = 32'h0000_0000;
        err_count = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("pc reset", pc, RESET_VECTOR);
        chk("stack empty", full, 0);
        rd(REG_PC_LOW, 32'h0000_0000);
        rd(REG_TABLE_HIGH, {24'h0, TBH_RESET});
        rd(4'h2, 32'h0000_0000);
        issue(PSS_OP_NONE, 11'h000, 8'h00);
        chk("step pc", pc, 11'(lastpc + 11'h1));
        chk("phase", ph, PHASE_FETCH);
        count_iv(1);
        @(posedge clk);
        ce <= 1'b0;
        t = pc;
        repeat (8) @(posedge clk);
        ce <= 1'b1;
        chk("frozen pc", pc, t);
        repeat (3) begin
            t = 11'($urandom) & 11'h7fe;
            issue(PSS_OP_JUMP, t, 8'h00);
            chk("jump pc", pc, t);
            count_iv(0);
            chk("after jump pc", pc, 11'(t + 11'h1));
        end
        issue(PSS_OP_SKIP, 11'h000, 8'h00);
        count_iv(0);
        b = 8'($urandom) & 8'hfe;
        t = pc;
        wb(1'b1, REG_PC_LOW, {24'h0, b});
        chk("pcl jump", pc, {t[10:8], b});
        for (int i = 0; i < 7; i++) begin
            issue(PSS_OP_CALL, 11'h100 + 11'(i * 16), 8'h00);
            stk.push_front(lastpc);
            chk("call pc", pc, 11'h100 + 11'(i * 16));
        end
        void'(stk.pop_back());
        chk("stack full", full, 1);
        @(posedge clk);
        irq <= 1'b1;
        n = 0;
        repeat (12) begin
            @(posedge clk);
            n += int'(ack);
        end
        chk("held ack", n, 0);
        issue(PSS_OP_RETURN, 11'h000, 8'h00);
        chk("ret pc", pc, stk.pop_front());
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        q = pc;
        irq <= 1'b0;
        chk("late ack", n < 40, 1);
        #1;
        chk("vector pc", pc, vec);
        stk.push_front(q);
        while (stk.size() > 0) begin
            issue(PSS_OP_RETURN, 11'h000, 8'h00);
            chk("ret pc", pc, stk.pop_front());
        end
        chk("stack drained", full, 0);
        for (int k = 0; k < 2; k++) begin
            lp = 8'($urandom);
            hp = 3'($urandom);
            wb(1'b1, REG_TBLP, {24'h0, lp});
            wb(1'b1, REG_TBHP, {29'h0, hp});
            b = 8'($urandom);
            w = word(k == 1 ? {LAST_PAGE, lp} : {hp, lp});
            q_dwr.push_back({b, w[7:0]});
            issue(k == 1 ? PSS_OP_TAB_LAST : PSS_OP_TABRD, 11'h000, b);
            repeat (4) @(posedge clk);
            #1;
            chk("table cycles", dwr.we, 1);
            wb(1'b1, REG_TABLE_HIGH, 32'h0000_00ff);
            rd(REG_TABLE_HIGH, {24'h0, w[15:8]});
        end
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule
